// ==== pwb_cfg.svh ====
// pwb_cfg.svh: widths, register indices, field positions and reset values
// of the pulse-width / rate-multiplier dac block.
// assumes: included by bare name from the package, pwb_top and the testbench.
`ifndef PWB_CFG_SVH
`define PWB_CFG_SVH

// counter and channel widths
`define PWB_CNT_W 12
`define PWB_LOW_W 6
`define PWB_FINE10_W 4
`define PWB_FINE12_W 6
`define PWB_NUM_CH 5

// apb: printed offsets are indices, byte address is four times the index
`define PWB_ADDR_W 8
`define PWB_IDX_PWM0 6'h22
`define PWB_IDX_BRM0 6'h23
`define PWB_IDX_PWM1 6'h24
`define PWB_IDX_BRM21 6'h25
`define PWB_IDX_PWM2 6'h26
`define PWB_IDX_PWM3 6'h27
`define PWB_IDX_BRM43 6'h28
`define PWB_IDX_PWM4 6'h29
`define PWB_IDX_STAT 6'h2A

// field positions
`define PWB_RSV_BIT 7
`define PWB_INV_BIT 6
`define PWB_STAT_OUT_LSB 16

// reset values
`define PWB_WEIGHT_RST 6'h00
`define PWB_RMV_RST 6'h00
`define PWB_CNT_RST 12'h000

`endif

// ==== pwb_pkg.sv ====
// pwb_pkg: shared types of the pulse-width / rate-multiplier dac block.
// assumes: pwb_cfg.svh is on the include path.
`include "pwb_cfg.svh"

package pwb_pkg;
    typedef logic [`PWB_CNT_W-1:0] pwb_cnt_t;
    typedef logic [`PWB_LOW_W-1:0] pwb_weight_t;
    typedef logic [`PWB_FINE12_W-1:0] pwb_rmv_t;
    // decoded register select of one apb access
    typedef enum {
        PWB_SEL_NONE, PWB_SEL_PWM0, PWB_SEL_BRM0, PWB_SEL_PWM1, PWB_SEL_BRM21,
        PWB_SEL_PWM2, PWB_SEL_PWM3, PWB_SEL_BRM43, PWB_SEL_PWM4, PWB_SEL_STAT
    } pwb_sel_t;
endpackage : pwb_pkg

// ==== pwb_counter.sv ====
// pwb_counter: free-running counter shared by all dac channels.
// assumes: single clock domain, asynchronous active-low reset.
`timescale 1ns/1ns

module pwb_counter #(
    parameter int W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic [W-1:0] count
);
    // steps every clock, never reloads; wraps naturally
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else begin
            count <= count + W'(1); // [RULE2]
        end
    end
endmodule : pwb_counter

// ==== pwb_channel.sv ====
// pwb_channel: one pwm channel with rate-multiplier widening.
// assumes: low_count and cycle are fields of the shared counter.
`timescale 1ns/1ns

module pwb_channel #(
    parameter int RMW = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [5:0] low_count,
    input wire logic [RMW-1:0] cycle,
    input wire logic [5:0] weight,
    input wire logic invert,
    input wire logic [RMW-1:0] rmv,
    output logic level_out
);
    logic [RMW-1:0] next_cycle;
    logic widen;
    logic level;

    // bit j picks cycles whose lowest set bit is RMW-1-j; top bit = odd
    function automatic logic rm_select(input logic [RMW-1:0] code,
                                       input logic [RMW-1:0] cyc);
        logic hit;
        logic [RMW-1:0] below;
        hit = 1'b0;
        for (int j = 0; j < RMW; j++) begin
            below = cyc << (RMW - (RMW - 1 - j));
            if (code[j] && cyc[RMW-1-j] && below == '0) begin
                hit = 1'b1; // [RULE9] [RULE16] [RULE10]
            end
        end
        return hit;
    endfunction : rm_select

    // extra clock sits in the last count before the selected cycle starts
    assign next_cycle = cycle + RMW'(1); // [RULE18]
    assign widen = (low_count == 6'h3F) && rm_select(rmv, next_cycle); // [RULE8] [RULE12]
    // high from wrap to match; a zero weight sets only on widen clocks [RULE3] [RULE4] [RULE11]
    assign level = (low_count < weight) || widen; // [RULE15]

    // registered pin level, low from reset on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_out <= 1'b0; // [RULE7]
        end else begin
            level_out <= level ^ invert; // [RULE6] [RULE13]
        end
    end
endmodule : pwb_channel

// ==== pwb_top.sv ====
// pwb_top: five-channel pulse-width dac with rate-multiplier fine steps,
// apb register slave, shared counter and per-channel output flops.
// assumes: one clock pclk, asynchronous active-low presetn, apb master
// keeps address and data stable through the access phase.
`timescale 1ns/1ns
`include "pwb_cfg.svh"

// Behaviour
// [RULE1] one 12-bit counter is shared by every channel.
// [RULE2] the counter steps by one every clock, never stops or reloads.
// [RULE3] low six counter bits wrapping to zero sets active outputs high.
// [RULE4] output goes low when low six bits equal the channel weight.
// [RULE5] 10-bit channel value is 6-bit weight plus 4-bit rate value.
// [RULE6] each channel's polarity can be inverted; usable as logic output.
// [RULE7] after reset every output pin is driven low.
// [RULE8] selected cycles get one extra clock at the pulse start.
// [RULE9] 4-bit rate value picks cycles 8; 4,12; 2,6,10,14; odd ones.
// [RULE10] several rate bits widen on the union of their cycles.
// [RULE11] zero weight, zero rate, no inversion keeps output low.
// [RULE12] full weight and rate: high in cycles 1-15, one clock low.
// [RULE13] zero weight and rate with inversion keeps output high.
// [RULE14] 12-bit channel value is 6-bit weight plus 6-bit rate value.
// [RULE15] 12-bit channel sets and clears its pulse like the others.
// [RULE16] 6-bit rate value picks from 64 cycles; lowest bit picks 32.
// [RULE17] weight register: bit 6 invert, bits 5-0 weight, bit 7 reads one.
// [RULE18] cycle number comes from counter bits just above the low six.
module pwb_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PWB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [`PWB_NUM_CH-1:0] dac_out
);
    import pwb_pkg::*;

    pwb_cnt_t count;
    pwb_weight_t weight [`PWB_NUM_CH];
    logic [`PWB_NUM_CH-1:0] output_invert;
    pwb_rmv_t rate_multiplier_value [`PWB_NUM_CH];
    pwb_sel_t sel;
    logic wr_en;
    logic setup;
    logic [31:0] next_prdata;

    // address decode; the word index is the printed offset
    always_comb begin
        case (paddr[`PWB_ADDR_W-1:2])
            `PWB_IDX_PWM0: sel = PWB_SEL_PWM0;
            `PWB_IDX_BRM0: sel = PWB_SEL_BRM0;
            `PWB_IDX_PWM1: sel = PWB_SEL_PWM1;
            `PWB_IDX_BRM21: sel = PWB_SEL_BRM21;
            `PWB_IDX_PWM2: sel = PWB_SEL_PWM2;
            `PWB_IDX_PWM3: sel = PWB_SEL_PWM3;
            `PWB_IDX_BRM43: sel = PWB_SEL_BRM43;
            `PWB_IDX_PWM4: sel = PWB_SEL_PWM4;
            `PWB_IDX_STAT: sel = PWB_SEL_STAT;
            default: sel = PWB_SEL_NONE;
        endcase
    end

    // writes land only at the access edge; all writable registers live in lane 0
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && pstrb[0];

    // weight and polarity registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < `PWB_NUM_CH; k++) begin
                weight[k] <= `PWB_WEIGHT_RST;
            end
            output_invert <= '0;
        end else if (wr_en) begin
            case (sel)
                PWB_SEL_PWM0: begin
                    weight[0] <= pwdata[5:0]; // [RULE17]
                    output_invert[0] <= pwdata[`PWB_INV_BIT]; // [RULE6]
                end
                PWB_SEL_PWM1: begin
                    weight[1] <= pwdata[5:0];
                    output_invert[1] <= pwdata[`PWB_INV_BIT];
                end
                PWB_SEL_PWM2: begin
                    weight[2] <= pwdata[5:0];
                    output_invert[2] <= pwdata[`PWB_INV_BIT];
                end
                PWB_SEL_PWM3: begin
                    weight[3] <= pwdata[5:0];
                    output_invert[3] <= pwdata[`PWB_INV_BIT];
                end
                PWB_SEL_PWM4: begin
                    weight[4] <= pwdata[5:0];
                    output_invert[4] <= pwdata[`PWB_INV_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // rate-multiplier registers; two 4-bit channels share one byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < `PWB_NUM_CH; k++) begin
                rate_multiplier_value[k] <= `PWB_RMV_RST;
            end
        end else if (wr_en) begin
            case (sel)
                PWB_SEL_BRM0: begin
                    rate_multiplier_value[0] <= pwdata[5:0]; // [RULE14]
                end
                PWB_SEL_BRM21: begin
                    rate_multiplier_value[1] <= {2'b00, pwdata[3:0]}; // [RULE5]
                    rate_multiplier_value[2] <= {2'b00, pwdata[7:4]};
                end
                PWB_SEL_BRM43: begin
                    rate_multiplier_value[3] <= {2'b00, pwdata[3:0]};
                    rate_multiplier_value[4] <= {2'b00, pwdata[7:4]};
                end
                default: begin
                end
            endcase
        end
    end

    // read mux; unused bits above the fields read as one where the
    // register resets them to one, zero elsewhere
    always_comb begin
        next_prdata = 32'h0000_0000;
        case (sel)
            PWB_SEL_PWM0: next_prdata[7:0] = {1'b1, output_invert[0], weight[0]}; // [RULE17]
            PWB_SEL_PWM1: next_prdata[7:0] = {1'b1, output_invert[1], weight[1]};
            PWB_SEL_PWM2: next_prdata[7:0] = {1'b1, output_invert[2], weight[2]};
            PWB_SEL_PWM3: next_prdata[7:0] = {1'b1, output_invert[3], weight[3]};
            PWB_SEL_PWM4: next_prdata[7:0] = {1'b1, output_invert[4], weight[4]};
            PWB_SEL_BRM0: next_prdata[7:0] = {2'b11, rate_multiplier_value[0]};
            PWB_SEL_BRM21: next_prdata[7:0] = {rate_multiplier_value[2][3:0],
                                               rate_multiplier_value[1][3:0]};
            PWB_SEL_BRM43: next_prdata[7:0] = {rate_multiplier_value[4][3:0],
                                               rate_multiplier_value[3][3:0]};
            PWB_SEL_STAT: begin
                next_prdata[`PWB_CNT_W-1:0] = count;
                next_prdata[`PWB_STAT_OUT_LSB +: `PWB_NUM_CH] = dac_out;
            end
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    // bus answer captured in the setup cycle, so every access has
    // exactly one access-phase cycle and no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && (sel == PWB_SEL_NONE);
            prdata <= (setup && !pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    // one counter for all channels
    pwb_counter #(
        .W(`PWB_CNT_W)
    ) u_counter (
        .pclk(pclk),
        .presetn(presetn),
        .count(count) // [RULE1]
    );

    // 12-bit channel: cycle number from counter bits 11:6
    pwb_channel #(
        .RMW(`PWB_FINE12_W)
    ) u_chan0 (
        .pclk(pclk),
        .presetn(presetn),
        .low_count(count[5:0]),
        .cycle(count[11:6]), // [RULE18]
        .weight(weight[0]),
        .invert(output_invert[0]),
        .rmv(rate_multiplier_value[0]),
        .level_out(dac_out[0])
    );

    // 10-bit channels: cycle number from counter bits 9:6
    for (genvar g = 1; g < `PWB_NUM_CH; g++) begin : g_chan
        pwb_channel #(
            .RMW(`PWB_FINE10_W)
        ) u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .low_count(count[5:0]),
            .cycle(count[9:6]), // [RULE18]
            .weight(weight[g]),
            .invert(output_invert[g]),
            .rmv(rate_multiplier_value[g][3:0]),
            .level_out(dac_out[g])
        );
    end

    // checks on the running generator
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // the first edge after a release still sees the reset value as its past
    counter_step_a: assert property ( // [RULE2]
        $past(presetn) |-> count == $past(count) + 12'h001
    ) else $error("shared counter did not step by one");

    set_on_wrap_a: assert property ( // [RULE3]
        (count[5:0] == 6'h00 && weight[1] != 6'h00)
        |=> dac_out[1] == !$past(output_invert[1])
    ) else $error("channel not set when low counter field wrapped");

    clear_on_match_a: assert property ( // [RULE4]
        (count[5:0] == weight[1] && weight[1] != 6'h3F)
        |=> dac_out[1] == $past(output_invert[1])
    ) else $error("channel not cleared on weight match");

    widen_cycle_a: assert property ( // [RULE9]
        (rate_multiplier_value[1] == 6'h01 && weight[1] != 6'h3F && count[5:0] == 6'h3F)
        |=> dac_out[1] == (($past(count[9:6]) == 4'h7) ^ $past(output_invert[1]))
    ) else $error("extra clock not placed before cycle eight only");

    union_widen_a: assert property ( // [RULE10]
        (rate_multiplier_value[2] == 6'h03 && weight[2] != 6'h3F && count[5:0] == 6'h3F)
        |=> dac_out[2] == (($past(count[9:6]) == 4'h3 || $past(count[9:6]) == 4'h7
                            || $past(count[9:6]) == 4'hB) ^ $past(output_invert[2]))
    ) else $error("combined rate bits did not widen on the union");

    zero_low_a: assert property ( // [RULE11]
        (weight[1] == 6'h00 && rate_multiplier_value[1] == 6'h00 && !output_invert[1])
        |=> !dac_out[1]
    ) else $error("zero setting did not hold output low");

    full_scale_a: assert property ( // [RULE12]
        (weight[1] == 6'h3F && rate_multiplier_value[1] == 6'h0F && !output_invert[1])
        |=> dac_out[1] == ($past(count[9:0]) != 10'h3FF)
    ) else $error("full scale output not low for exactly one clock");

    invert_high_a: assert property ( // [RULE13]
        (weight[3] == 6'h00 && rate_multiplier_value[3] == 6'h00 && output_invert[3])
        |=> dac_out[3]
    ) else $error("inverted zero setting did not hold output high");

    fine12_widen_a: assert property ( // [RULE16]
        (rate_multiplier_value[0] == 6'h01 && weight[0] != 6'h3F && count[5:0] == 6'h3F)
        |=> dac_out[0] == (($past(count[11:6]) == 6'h1F) ^ $past(output_invert[0]))
    ) else $error("12-bit channel extra clock not before cycle 32");

    reserved_read_a: assert property ( // [RULE17]
        (psel && penable && pready && !pwrite && paddr[7:2] == `PWB_IDX_PWM2)
        |-> prdata[`PWB_RSV_BIT]
    ) else $error("reserved weight register bit did not read as one");

    reset_low_a: assert property (@(posedge pclk) disable iff (1'b0) // [RULE7]
        !presetn |-> dac_out == '0
    ) else $error("outputs not low during reset");

    // bus answer: one access cycle after every setup, error only on a hole
    ready_timing_a: assert property ( // [RULE17]
        $past(presetn) |-> pready == $past(psel && !penable)
    ) else $error("ready not high exactly in the access cycle");

    error_unmapped_a: assert property ( // [RULE17]
        $past(presetn) |-> pslverr == (pready && $past(sel == PWB_SEL_NONE))
    ) else $error("slave error does not match the address decode");

    rdata_idle_a: assert property ( // [RULE17]
        !pready |-> prdata == 32'h0000_0000
    ) else $error("read data not zero outside a read access");

    invert_read_a: assert property ( // [RULE17]
        (psel && penable && pready && !pwrite && paddr[7:2] == `PWB_IDX_PWM4)
        |-> prdata[`PWB_INV_BIT] == output_invert[4]
    ) else $error("polarity bit does not read back");

    stat_read_a: assert property ( // [RULE1]
        (psel && penable && pready && !pwrite && paddr[7:2] == `PWB_IDX_STAT)
        |-> prdata[11:0] == $past(count) && prdata[20:16] == $past(dac_out)
    ) else $error("status word does not show the counter and pins");

    // register packing; a write without its lane strobe must leave all alone
    strobe_ignore_a: assert property ( // [RULE17]
        (psel && penable && pready && pwrite && !pstrb[0])
        |=> $stable(weight[1]) && $stable(output_invert)
    ) else $error("write without byte strobe changed a register");

    invert_write_a: assert property ( // [RULE6]
        !$past(wr_en) |-> $stable(output_invert)
    ) else $error("polarity changed without a write");

    rate_pack_a: assert property ( // [RULE5]
        (psel && penable && pready && pwrite && pstrb[0] && paddr[7:2] == `PWB_IDX_BRM21)
        |=> rate_multiplier_value[1] == {2'b00, $past(pwdata[3:0])}
            && rate_multiplier_value[2] == {2'b00, $past(pwdata[7:4])}
    ) else $error("shared rate byte not split onto its two channels");

    fine12_write_a: assert property ( // [RULE14]
        (psel && penable && pready && pwrite && pstrb[0] && paddr[7:2] == `PWB_IDX_BRM0)
        |=> rate_multiplier_value[0] == $past(pwdata[5:0])
    ) else $error("12-bit channel rate value not written whole");

    // 12-bit channel coarse pulse and further widening cases
    wide_set_a: assert property ( // [RULE15]
        (count[5:0] == 6'h00 && weight[0] != 6'h00)
        |=> dac_out[0] == !$past(output_invert[0])
    ) else $error("12-bit channel not set on wrap");

    wide_clear_a: assert property ( // [RULE15]
        (count[5:0] == weight[0] && weight[0] != 6'h3F)
        |=> dac_out[0] == $past(output_invert[0])
    ) else $error("12-bit channel not cleared on weight match");

    lone_pulse_a: assert property ( // [RULE8]
        (weight[1] == 6'h00 && rate_multiplier_value[1] == 6'h0F && !output_invert[1]
         && count[5:0] == 6'h3F)
        |=> dac_out[1] == ($past(count[9:6]) != 4'hF)
    ) else $error("zero weight did not give lone widening clocks");

    mixed_widen_a: assert property ( // [RULE10]
        (rate_multiplier_value[4] == 6'h05 && weight[4] != 6'h3F && count[5:0] == 6'h3F)
        |=> dac_out[4] == (($past(count[9:6]) == 4'h7 || $past(count[7:6]) == 2'h1)
                           ^ $past(output_invert[4]))
    ) else $error("rate code five did not widen on its union");

    // main scenarios
    full_scale_c: cover property (
        weight[1] == 6'h3F && rate_multiplier_value[1] == 6'h0F && count[9:0] == 10'h3FF
    );
    widen_seen_c: cover property (
        rate_multiplier_value[0] != 6'h00 && count[5:0] == 6'h3F ##1 dac_out[0]
    );
    invert_hold_c: cover property (
        output_invert[4] && weight[4] == 6'h00 ##1 dac_out[4]
    );
    apb_error_c: cover property (psel && penable && pslverr);
    rate_write_c: cover property (psel && penable && pready && pwrite
                                  && paddr[7:2] == `PWB_IDX_BRM43);
endmodule : pwb_top

// ==== pwb_rc_model.sv ====
// pwb_rc_model: stands in for the rc filter on one dac pin; it integrates
// the pin level and counts pulse starts inside a measurement window.
// assumes: pin is a registered output of the pwb_top clock domain.
`timescale 1ns/1ns

module pwb_rc_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    input wire logic win,
    input wire logic clr,
    output logic [15:0] charge,
    output logic [15:0] rises
);
    logic prev;

    // last pin level, kept outside the window too so the first sample is judged right
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= 1'b0;
        end else begin
            prev <= pin;
        end
    end

    // a whole-period sum of high clocks gives the same mean as the capacitor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            charge <= 16'h0000;
            rises <= 16'h0000;
        end else if (clr) begin
            charge <= 16'h0000;
            rises <= 16'h0000;
        end else if (win) begin
            charge <= charge + 16'(pin);
            rises <= rises + 16'(pin & ~prev);
        end
    end
endmodule : pwb_rc_model

// ==== tb_top.sv ====
// tb_top: apb bench for the pulse-width dac; programs all five channels,
// lets rc models integrate each pin, and checks charge and pulse counts.
// assumes: pwb_top as the only design, one 250 MHz clock.
`timescale 1ns/1ns
`include "pwb_cfg.svh"

`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("BAD %0t got %0h exp %0h", $time, (got), (exp)); \
        end \
    end

module tb_top;
    logic pclk = 1'b0;
    logic presetn;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [`PWB_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [`PWB_NUM_CH-1:0] dac_out;
    logic win = 1'b0;
    logic clr = 1'b0;
    wire [15:0] charge [5];
    wire [15:0] rises [5];
    logic [31:0] rd;
    logic err;
    logic [11:0] c1;
    int s1, run, ch, k, hi;
    int bad_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int setup_cyc = 0;
    logic [5:0] pwm_idx [5] = '{`PWB_IDX_PWM0, `PWB_IDX_PWM1, `PWB_IDX_PWM2,
        `PWB_IDX_PWM3, `PWB_IDX_PWM4};
    // per run and channel: weight, invert, rate value, expected pulse starts
    int cw [15] = '{63, 63, 0, 0, 24, 0, 2, 5, 1, 0, 32, 0, 63, 10, 1};
    int ci [15] = '{0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 1, 0, 0, 1, 0};
    int cr [15] = '{63, 15, 0, 0, 6, 1, 8, 4, 2, 1, 32, 15, 0, 0, 5};
    int ce [15] = '{1, 4, 0, 0, 64, 1, 64, 64, 64, 4, 64, 60, 64, 64, 64};

    always #2 pclk = ~pclk;

    // edge counter lets counter reads be checked without assuming bus latency
    always @(posedge pclk) cyc <= cyc + 1;

    pwb_top u_pwb_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dac_out(dac_out));

    for (genvar i = 0; i < 5; i++) begin : g_rc
        pwb_rc_model u_pwb_rc_model (.pclk(pclk), .presetn(presetn), .pin(dac_out[i]),
            .win(win), .clr(clr), .charge(charge[i]), .rises(rises[i]));
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // one apb transfer; the request is held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
        input logic [3:0] st = 4'hF);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        setup_cyc = cyc;
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            bad_count++;
            print_verdict();
        end
    endtask : apb

    initial begin
        // a real falling edge at time zero clears every flop before the first clock
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(dac_out, 5'h00)
        apb(0, `PWB_IDX_PWM0, 32'h0);
        `CHK(rd, 32'h00000080)
        apb(0, `PWB_IDX_BRM0, 32'h0);
        `CHK(rd, 32'h000000C0)
        apb(0, `PWB_IDX_BRM21, 32'h0);
        `CHK(rd, 32'h00000000)
        // a write without its byte strobe and a write to the status word change nothing
        apb(1, `PWB_IDX_PWM1, 32'h0000007F, 4'h0);
        apb(0, `PWB_IDX_PWM1, 32'h0);
        `CHK(rd, 32'h00000080)
        apb(1, `PWB_IDX_STAT, 32'h000000FF);
        `CHK(err, 1'b0)
        apb(0, 6'h00, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h00000000)
        // counter steps once per clock and wraps at twelve bits across a long gap
        apb(0, `PWB_IDX_STAT, 32'h0);
        c1 = rd[11:0];
        s1 = setup_cyc;
        repeat (5000) @(posedge pclk);
        apb(0, `PWB_IDX_STAT, 32'h0);
        `CHK(rd[11:0] - c1, 12'(setup_cyc - s1))
        for (run = 0; run < 3; run++) begin
            k = run * 5;
            for (ch = 0; ch < 5; ch++) begin
                apb(1, pwm_idx[ch], {24'h0, 1'b0, ci[k + ch][0], cw[k + ch][5:0]});
            end
            apb(1, `PWB_IDX_BRM0, {26'h0, cr[k][5:0]});
            apb(1, `PWB_IDX_BRM21, {24'h0, cr[k + 2][3:0], cr[k + 1][3:0]});
            apb(1, `PWB_IDX_BRM43, {24'h0, cr[k + 4][3:0], cr[k + 3][3:0]});
            apb(0, `PWB_IDX_PWM4, 32'h0);
            `CHK(rd, {24'h0, 1'b1, ci[k + 4][0], cw[k + 4][5:0]})
            // one window of 4096 clocks covers whole periods of every channel
            @(posedge pclk);
            clr <= 1'b1;
            @(posedge pclk);
            clr <= 1'b0;
            win <= 1'b1;
            repeat (4096) @(posedge pclk);
            win <= 1'b0;
            @(posedge pclk);
            for (ch = 0; ch < 5; ch++) begin
                hi = (ch == 0) ? 64 * cw[k + ch] + cr[k + ch] : 4 * (16 * cw[k + ch] + cr[k + ch]);
                if (ci[k + ch] != 0) hi = 4096 - hi;
                `CHK(charge[ch], 16'(hi))
                `CHK(rises[ch], 16'(ce[k + ch]))
            end
            // pins shown in the status word: first run holds ch2 low and ch3 high
            apb(0, `PWB_IDX_STAT, 32'h0);
            if (run == 0) `CHK(rd[19:18], 2'b10)
        end
        // reset in mid-run with channels busy must pull every pin low
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        `CHK(dac_out, 5'h00)
        presetn <= 1'b1;
        apb(0, `PWB_IDX_PWM4, 32'h0);
        `CHK(rd, 32'h00000080)
        print_verdict();
    end
endmodule : tb_top
